//--- inc/sdc_consts.svh
// Offsets, field positions, reset values and counts of the converter.
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH
`define SDC_OFF_CON1 12'h000
`define SDC_OFF_CON2 12'h004
`define SDC_OFF_CON3 12'h008
`define SDC_OFF_RESH 12'h00c
`define SDC_OFF_RESL 12'h010
`define SDC_CON1_MASK 16'hbfd7
`define SDC_CON2_MASK 16'hf318
`define SDC_CON3_MASK 16'hff07
`define SDC_CON_RESET 16'h0000
`define SDC_ON_BIT 15
`define SDC_SIDL_BIT 13
`define SDC_SRST_BIT 12
`define SDC_GAIN_LSB 8
`define SDC_DITH_LSB 6
`define SDC_OFFS_BIT 4
`define SDC_REFN_BIT 2
`define SDC_REFP_BIT 1
`define SDC_BW_BIT 0
`define SDC_CHOPPING_SEL_LSB 14
`define SDC_IRQ_LSB 12
`define SDC_WM_LSB 8
`define SDC_RND_LSB 3
`define SDC_RDY_BIT 0
`define SDC_DIV_LSB 13
`define SDC_OSR_LSB 10
`define SDC_CS_LSB 8
`define SDC_CH_LSB 0
`define SDC_IRQ_EVERY 2'h3
`define SDC_IRQ_FIFTH 2'h2
`define SDC_IRQ_FALL 2'h1
`define SDC_IRQ_RISE 2'h0
`define SDC_WM_UNTIL 2'h0
`define SDC_WM_ALWAYS 2'h1
`define SDC_WM_NEVER 2'h2
`define SDC_CHOPPING_SEL_ON 2'h3
`define SDC_FIFTH_LAST 3'h4
`define SDC_SETTLE 3
`define SDC_OSR_MAX 11'h400
`define SDC_OSR_SHIFT0 5'h14
`define SDC_CODE_RSVD 3'h7
`define SDC_CODE_TOP 3'h6
`endif

//--- inc/sdc_pkg.sv
// Types and shared arithmetic of the converter.
package sdc_pkg;
  `include "sdc_consts.svh"
  typedef logic [31:0] sdc_word_t;
  typedef logic [15:0] sdc_half_t;
  typedef logic [11:0] sdc_addr_t;

  // Reserved code 111 of the ratio and divider fields acts as 110.
  function automatic logic [2:0] sdc_code(input logic [2:0] c);
    return (c == `SDC_CODE_RSVD) ? `SDC_CODE_TOP : c;
  endfunction

  function automatic logic [10:0] sdc_osr_len(input logic [2:0] c);
    return `SDC_OSR_MAX >> sdc_code(c);
  endfunction

  // Round half up to the kept bits, saturating at positive full scale.
  function automatic sdc_word_t sdc_round(input sdc_word_t v,
                                          input logic [1:0] c);
    sdc_word_t m;
    sdc_word_t h;
    logic [32:0] s;
    case (c)
      2'h1: begin m = 32'hffffff00; h = 32'h00000080; end
      2'h2: begin m = 32'hffff0000; h = 32'h00008000; end
      2'h3: begin m = 32'hff000000; h = 32'h00800000; end
      default: begin m = 32'hffffffff; h = 32'h00000000; end
    endcase
    s = {v[31], v} + {1'b0, h};
    if (!v[31] && s[31]) return 32'h7fffffff & m;
    return s[31:0] & m;
  endfunction
endpackage

//--- inc/sdc_core_if.sv
// Signals between the converter top, its clock generator and filter.
`timescale 1ns/10ps
`default_nettype none
interface sdc_core_if;
  logic        ce;
  logic        run;
  logic        clear;
  logic        mod_bit;
  logic        frc_tick;
  logic        posc_tick;
  logic [1:0]  src_sel;
  logic [2:0]  div_sel;
  logic [2:0]  osr_sel;
  logic        mod_tick;
  logic        sample_valid;
  logic [31:0] sample_data;
  modport top (output ce, run, clear, mod_bit, frc_tick, posc_tick,
               output src_sel, div_sel, osr_sel,
               input mod_tick, sample_valid, sample_data);
  modport clkgen (input ce, run, src_sel, div_sel, frc_tick, posc_tick,
                  output mod_tick);
  modport filt (input ce, run, clear, mod_bit, mod_tick, osr_sel,
                output sample_valid, sample_data);
endinterface
`default_nettype wire

//--- core/sdc_clkgen.sv
// Module clock selection and power-of-two divider.
`timescale 1ns/10ps
`default_nettype none
module sdc_clkgen (
  // Clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // Core signals
  sdc_core_if.clkgen cif
);
  import sdc_pkg::*;
  logic [5:0] cnt_q;
  logic [5:0] last;
  logic       src;
  logic       tick_q;

  always_comb begin
    case (cif.src_sel) // see [RULE_21]
      2'h0: src = 1'b1;
      2'h1: src = cif.frc_tick;
      2'h2: src = cif.posc_tick;
      default: src = 1'b0;
    endcase
    last = 6'((7'h01 << sdc_code(cif.div_sel)) - 7'h01); // see [RULE_21]
  end

  // The divider sets the data rate together with the oversampling.
  always_ff @(posedge pclk or negedge presetn) begin // see [RULE_17]
    if (!presetn) begin
      cnt_q  <= 6'h00;
      tick_q <= 1'b0;
    end else if (cif.ce) begin
      tick_q <= 1'b0;
      if (!cif.run) begin
        cnt_q <= 6'h00;
      end else if (src) begin
        if (cnt_q >= last) begin
          cnt_q  <= 6'h00;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end
  assign cif.mod_tick = tick_q;
endmodule // sdc_clkgen
`default_nettype wire

//--- core/sdc_filter.sv
// Decimation of the modulator bit stream into signed samples.
`timescale 1ns/10ps
`default_nettype none
`include "sdc_consts.svh"
module sdc_filter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core signals
  sdc_core_if.filt cif
);
  import sdc_pkg::*;
  logic [10:0] cnt_q;
  logic [10:0] ones_q;
  logic [10:0] sum;
  logic [10:0] len;
  logic [31:0] diff;
  logic [4:0]  sh;
  logic        vld_q;
  logic [31:0] data_q;

  // Full scale is 2**30 for every ratio, so the shift never overflows.
  always_comb begin
    len  = sdc_osr_len(cif.osr_sel); // see [RULE_19]
    sum  = ones_q + {10'h000, cif.mod_bit};
    diff = {20'h00000, sum, 1'b0} - {21'h000000, len};
    sh   = `SDC_OSR_SHIFT0 + {2'h0, sdc_code(cif.osr_sel)};
  end

  always_ff @(posedge pclk or negedge presetn) begin // see [RULE_16]
    if (!presetn) begin
      cnt_q  <= 11'h000;
      ones_q <= 11'h000;
      vld_q  <= 1'b0;
      data_q <= 32'h00000000;
    end else if (cif.ce) begin
      vld_q <= 1'b0;
      if (cif.clear) begin
        cnt_q  <= 11'h000;
        ones_q <= 11'h000;
      end else if (cif.run && cif.mod_tick) begin
        if (cnt_q >= len - 11'h001) begin
          cnt_q  <= 11'h000;
          ones_q <= 11'h000;
          vld_q  <= 1'b1;
          data_q <= diff << sh;
        end else begin
          cnt_q  <= cnt_q + 11'h001;
          ones_q <= sum;
        end
      end
    end
  end
  assign cif.sample_valid = vld_q;
  assign cif.sample_data  = data_q;
endmodule // sdc_filter
`default_nettype wire

//--- core/sdc_top.sv
// Sigma-delta converter control, result handling and APB registers.
//
// Contract
// [RULE_01] Converter runs only while module_on is set.
// [RULE_02] With stop_in_idle set the converter halts in Idle.
// [RULE_03] soft_reset clears the converter and holds analog in reset.
// [RULE_04] Software keeps the reserved control bit at zero.
// [RULE_05] input_gain_sel codes 0..5 give gain 1 to 32; 6, 7 reserved.
// [RULE_06] Dither field: none, low, medium, high.
// [RULE_07] offset_self_measure makes the converter sample its own offset.
// [RULE_08] neg_ref_sel picks external negative reference or ground.
// [RULE_09] pos_ref_sel picks external positive reference or supply.
// [RULE_10] amp_bandwidth_sel picks double or normal bandwidth.
// [RULE_11] chopping_sel 11 enables chopping, 00 disables; others reserved.
// [RULE_12] irq_event_sel: every sample, every fifth, falling or rising.
// [RULE_13] Results update until ready, always, or never per policy.
// [RULE_14] Rounding: none, or to 24, 16 or 8 bits.
// [RULE_15] Ready flag set by hardware once settled, cleared by software.
// [RULE_16] Oversampling ratio from 16 up to 1024.
// [RULE_17] Data rate set by clock divider and oversampling.
// [RULE_18] Unimplemented control bits read zero and ignore writes.
// [RULE_19] Ratio code 0 is 1024, halving per code down to 16.
// [RULE_20] Channel field picks input pair, single end or references.
// [RULE_21] Clock source chosen, then divided by 1 to 64.
// [RULE_22] Software keeps the converter clock between 1 and 4 MHz.
// [RULE_23] All control fields reset to zero at power-on.
// [RULE_24] Result is read as high and low 16-bit words.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sdc_consts.svh"
module sdc_top #(
  parameter int SETTLE = `SDC_SETTLE
) (
  // Clock, reset, enable
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         ce,
  // APB slave
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire sdc_pkg::sdc_addr_t paddr,
  input wire sdc_pkg::sdc_word_t pwdata,
  input wire logic [3:0]   pstrb,
  output logic             pready,
  output sdc_pkg::sdc_word_t prdata,
  output logic             pslverr,
  // System and modulator inputs
  input wire logic         idle_mode,
  input wire logic         frc_tick,
  input wire logic         posc_tick,
  input wire logic         mod_bit,
  // Analog controls and events
  output logic             analog_en,
  output logic             analog_rst,
  output logic [2:0]       gain_sel,
  output logic [1:0]       dither_sel,
  output logic             offset_meas,
  output logic             neg_ref,
  output logic             pos_ref,
  output logic             amp_bw,
  output logic             chopping_sel_en,
  output logic [2:0]       channel_sel,
  output logic             mod_strobe,
  output logic             irq_event
);
  import sdc_pkg::*;
  sdc_core_if cif ();

  sdc_half_t   con1_q;
  sdc_half_t   con2_q;
  sdc_half_t   con3_q;
  logic        rdy_q;
  sdc_word_t   res_q;
  sdc_word_t   last_q;
  logic [2:0]  fifth_q;
  logic [2:0]  settle_q;
  logic        pready_q;
  logic        pslverr_q;
  sdc_word_t   prdata_q;
  logic        aen_q, arst_q, offs_q, refn_q, refp_q, bw_q, chopping_sel_q;
  logic [2:0]  gain_q, ch_q;
  logic [1:0]  dith_q;
  logic        strobe_q, irq_q;
  logic        run, clr, setup, wr, sw_clr, set_rdy, ev, wr_res, mapped;
  logic [1:0]  irq_sel, wm_sel;
  sdc_word_t   rnd, rd;

  function automatic sdc_half_t merge(input sdc_half_t o,
                                      input sdc_half_t m);
    sdc_half_t n;
    n = o;
    if (pstrb[0]) n[7:0] = pwdata[7:0];
    if (pstrb[1]) n[15:8] = pwdata[15:8];
    return n & m;
  endfunction

  assign run = con1_q[`SDC_ON_BIT] && !con1_q[`SDC_SRST_BIT] && // see [RULE_01]
               !(con1_q[`SDC_SIDL_BIT] && idle_mode);        // see [RULE_02]
  assign clr = !con1_q[`SDC_ON_BIT] || con1_q[`SDC_SRST_BIT]; // see [RULE_03]
  assign cif.ce        = ce;
  assign cif.run       = run;
  assign cif.clear     = clr;
  assign cif.mod_bit   = mod_bit;
  assign cif.frc_tick  = frc_tick;
  assign cif.posc_tick = posc_tick;
  assign cif.src_sel   = con3_q[`SDC_CS_LSB +: 2];
  assign cif.div_sel   = con3_q[`SDC_DIV_LSB +: 3];
  assign cif.osr_sel   = con3_q[`SDC_OSR_LSB +: 3];

  sdc_clkgen u_clk (.pclk(pclk), .presetn(presetn), .cif(cif));
  sdc_filter u_flt (.pclk(pclk), .presetn(presetn), .cif(cif));

  // APB decode; read data are captured in the setup cycle, so one wait-free
  // access phase answers every transfer.
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pready_q && pwrite && ce;
  assign sw_clr = wr && paddr == `SDC_OFF_CON2 && pstrb[0] &&
                  !pwdata[`SDC_RDY_BIT];
  always_comb begin
    mapped = 1'b1;
    rd     = 32'h00000000;
    case (paddr)
      `SDC_OFF_CON1: rd[15:0] = con1_q;
      `SDC_OFF_CON2: rd[15:0] = con2_q | {15'h0000, rdy_q};
      `SDC_OFF_CON3: rd[15:0] = con3_q;
      `SDC_OFF_RESH: rd[15:0] = res_q[31:16]; // see [RULE_24]
      `SDC_OFF_RESL: rd[15:0] = res_q[15:0];
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (ce) begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= setup ? rd : 32'h00000000;
    end
  end

  // Control registers; the reserved bit is kept as written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con1_q <= `SDC_CON_RESET; // see [RULE_23]
      con2_q <= `SDC_CON_RESET;
      con3_q <= `SDC_CON_RESET;
    end else if (wr) begin
      if (paddr == `SDC_OFF_CON1)
        con1_q <= merge(con1_q, `SDC_CON1_MASK); // see [RULE_18]
      if (paddr == `SDC_OFF_CON2)
        con2_q <= merge(con2_q, `SDC_CON2_MASK); // see [RULE_18]
      if (paddr == `SDC_OFF_CON3)
        con3_q <= merge(con3_q, `SDC_CON3_MASK);
    end
  end

  assign irq_sel = con2_q[`SDC_IRQ_LSB +: 2];
  assign wm_sel  = con2_q[`SDC_WM_LSB +: 2];
  always_comb begin
    rnd = sdc_round(cif.sample_data, con2_q[`SDC_RND_LSB +: 2]); // see [RULE_14]
    case (irq_sel) // see [RULE_12]
      `SDC_IRQ_EVERY: ev = cif.sample_valid;
      `SDC_IRQ_FIFTH: ev = cif.sample_valid && fifth_q == `SDC_FIFTH_LAST;
      `SDC_IRQ_FALL:  ev = cif.sample_valid &&
                           $signed(rnd) < $signed(last_q);
      default:        ev = cif.sample_valid &&
                           $signed(rnd) > $signed(last_q);
    endcase
    wr_res = ev && (wm_sel == `SDC_WM_ALWAYS || // see [RULE_13]
                    (wm_sel == `SDC_WM_UNTIL && !rdy_q));
    set_rdy = cif.sample_valid && 32'(settle_q) >= SETTLE - 1;
  end

  // Result path and event counting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q    <= 32'h00000000;
      last_q   <= 32'h00000000;
      fifth_q  <= 3'h0;
      settle_q <= 3'h0;
      irq_q    <= 1'b0;
    end else if (ce) begin
      irq_q <= ev && !clr;
      if (clr) begin
        res_q    <= 32'h00000000;
        last_q   <= 32'h00000000;
        fifth_q  <= 3'h0;
        settle_q <= 3'h0;
      end else if (cif.sample_valid) begin
        last_q  <= rnd;
        fifth_q <= (fifth_q == `SDC_FIFTH_LAST) ? 3'h0 : fifth_q + 3'h1;
        if (32'(settle_q) < SETTLE) settle_q <= settle_q + 3'h1;
        if (wr_res) res_q <= rnd; // see [RULE_24]
      end
    end
  end

  // A new sample setting the flag beats a software clear in one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rdy_q <= 1'b0;
    else if (ce) begin
      if (clr) rdy_q <= 1'b0;
      else if (set_rdy) rdy_q <= 1'b1; // see [RULE_15]
      else if (sw_clr) rdy_q <= 1'b0;
    end
  end

  // Analog controls, registered for glitch-free pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aen_q    <= 1'b0;
      arst_q   <= 1'b0;
      gain_q   <= 3'h0;
      dith_q   <= 2'h0;
      offs_q   <= 1'b0;
      refn_q   <= 1'b0;
      refp_q   <= 1'b0;
      bw_q     <= 1'b0;
      chopping_sel_q   <= 1'b0;
      ch_q     <= 3'h0;
      strobe_q <= 1'b0;
    end else if (ce) begin
      aen_q    <= run;                               // see [RULE_01]
      arst_q   <= con1_q[`SDC_SRST_BIT];             // see [RULE_03]
      gain_q   <= con1_q[`SDC_GAIN_LSB +: 3];        // see [RULE_05]
      dith_q   <= con1_q[`SDC_DITH_LSB +: 2];        // see [RULE_06]
      offs_q   <= con1_q[`SDC_OFFS_BIT];             // see [RULE_07]
      refn_q   <= con1_q[`SDC_REFN_BIT];             // see [RULE_08]
      refp_q   <= con1_q[`SDC_REFP_BIT];             // see [RULE_09]
      bw_q     <= con1_q[`SDC_BW_BIT];               // see [RULE_10]
      chopping_sel_q   <= con2_q[`SDC_CHOPPING_SEL_LSB +: 2] == `SDC_CHOPPING_SEL_ON; // see [RULE_11]
      ch_q     <= con3_q[`SDC_CH_LSB +: 3];          // see [RULE_20]
      strobe_q <= cif.mod_tick;
    end
  end

  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign prdata      = prdata_q;
  assign analog_en   = aen_q;
  assign analog_rst  = arst_q;
  assign gain_sel    = gain_q;
  assign dither_sel  = dith_q;
  assign offset_meas = offs_q;
  assign neg_ref     = refn_q;
  assign pos_ref     = refp_q;
  assign amp_bw      = bw_q;
  assign chopping_sel_en     = chopping_sel_q;
  assign channel_sel = ch_q;
  assign mod_strobe  = strobe_q;
  assign irq_event   = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_off;
    ce && !con1_q[`SDC_ON_BIT] |=> !analog_en && !irq_event;
  endproperty
  a_off: assert property (p_off) else $error("enabled while off"); // see [RULE_01]
  property p_idle;
    ce && idle_mode && con1_q[`SDC_SIDL_BIT] |=> !analog_en;
  endproperty
  a_idle: assert property (p_idle) else $error("ran in idle"); // see [RULE_02]
  property p_srst;
    ce && con1_q[`SDC_SRST_BIT] |=> analog_rst && !rdy_q && res_q == 0;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset lost"); // see [RULE_03]
  property p_chopping_sel;
    ce |=> chopping_sel_en == ($past(con2_q[15:14]) == `SDC_CHOPPING_SEL_ON);
  endproperty
  a_chopping_sel: assert property (p_chopping_sel) else $error("chopping_sel decode"); // see [RULE_11]
  property p_every;
    ce && cif.sample_valid && !clr && irq_sel == `SDC_IRQ_EVERY
      |=> irq_event ##1 !irq_event || !ce;
  endproperty
  a_every: assert property (p_every) else $error("missed event"); // see [RULE_12]
  property p_fifth;
    ce && irq_sel == `SDC_IRQ_FIFTH && fifth_q != `SDC_FIFTH_LAST
      |=> !irq_event;
  endproperty
  a_fifth: assert property (p_fifth) else $error("early fifth"); // see [RULE_12]
  property p_never;
    ce && !clr && wm_sel == `SDC_WM_NEVER |=> $stable(res_q);
  endproperty
  a_never: assert property (p_never) else $error("result written"); // see [RULE_13]
  property p_hold;
    ce && rdy_q && !clr && !sw_clr |=> rdy_q;
  endproperty
  a_hold: assert property (p_hold) else $error("ready dropped"); // see [RULE_15]
  property p_early;
    rdy_q |-> 32'(settle_q) == SETTLE;
  endproperty
  a_early: assert property (p_early) else $error("ready too early"); // see [RULE_15]
  property p_apb;
    ce && setup |=> pready && (pslverr == !$past(mapped));
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer"); // see [RULE_18]

  property p_c_rdy;
    !rdy_q ##1 rdy_q;
  endproperty
  c_rdy: cover property (p_c_rdy);
  property p_c_irq;
    irq_event && wm_sel == `SDC_WM_UNTIL;
  endproperty
  c_irq: cover property (p_c_irq);
  property p_c_clr;
    set_rdy && sw_clr;
  endproperty
  c_clr: cover property (p_c_clr);
endmodule // sdc_top
`default_nettype wire

//--- testbench/sdc_mod_model.sv
// Stand-in for the modulator and the oscillators beyond the converter.
`timescale 1ns/10ps
`default_nettype none
module sdc_mod_model (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bit pattern: ones high bits in every per strobes
  input wire logic [10:0] per,
  input wire logic [10:0] ones,
  // Converter side
  input wire logic        mod_strobe,
  output logic            mod_bit,
  output logic            frc_tick,
  output logic            posc_tick
);
  logic [10:0] pos_q;
  logic [2:0]  tick_q;

  // Ticks stay at least four cycles apart so the pattern steps after each strobe
  // before the converter samples the next bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_q <= 3'h0;
    else tick_q <= tick_q + 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pos_q <= 11'h000;
    else if (mod_strobe && pos_q >= per - 11'h001) pos_q <= 11'h000;
    else if (mod_strobe) pos_q <= pos_q + 11'h001;
  end

  assign frc_tick = (tick_q[1:0] == 2'h0);
  assign posc_tick = (tick_q == 3'h0);
  assign mod_bit = (pos_q < ones);
endmodule // sdc_mod_model
`default_nettype wire

//--- testbench/sdc_top_tb.sv
// Self-checking bench of the converter through its register bus.
`timescale 1ns/10ps
`default_nettype none
`include "sdc_consts.svh"
module sdc_top_tb;
  import sdc_pkg::*;
  localparam sdc_addr_t c1a = `SDC_OFF_CON1;
  localparam sdc_addr_t c2a = `SDC_OFF_CON2;
  localparam sdc_addr_t c3a = `SDC_OFF_CON3;
  localparam sdc_addr_t rha = `SDC_OFF_RESH;
  localparam sdc_addr_t rla = `SDC_OFF_RESL;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        idle_mode = 1'b0;
  logic        ce = 1'b1;
  sdc_addr_t   paddr = '0;
  sdc_word_t   pwdata = '0;
  logic [10:0] per = 11'h010;
  logic [10:0] ones = 11'h010;
  logic        pready, pslverr, analog_en, analog_rst, offset_meas;
  logic        neg_ref, pos_ref, amp_bw, chopping_sel_en, mod_strobe, irq_event;
  logic        mod_bit, frc_tick, posc_tick;
  logic [2:0]  gain_sel, channel_sel;
  logic [1:0]  dither_sel;
  sdc_word_t   prdata;
  logic [34:0] q[$];
  int          fails = 0;
  int          n_checks = 0;

  always #5 pclk = ~pclk;

  sdc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .idle_mode(idle_mode), .frc_tick(frc_tick), .posc_tick(posc_tick),
    .mod_bit(mod_bit), .analog_en(analog_en), .analog_rst(analog_rst),
    .gain_sel(gain_sel), .dither_sel(dither_sel),
    .offset_meas(offset_meas), .neg_ref(neg_ref), .pos_ref(pos_ref),
    .amp_bw(amp_bw), .chopping_sel_en(chopping_sel_en), .channel_sel(channel_sel),
    .mod_strobe(mod_strobe), .irq_event(irq_event));

  sdc_mod_model far (.pclk(pclk), .presetn(presetn), .per(per),
    .ones(ones), .mod_strobe(mod_strobe), .mod_bit(mod_bit),
    .frc_tick(frc_tick), .posc_tick(posc_tick));

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    fails++;
    $display("[ERR] %0t no %s", $time, what);
    close_out();
  endtask

  // The request stays put until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input sdc_addr_t a, input sdc_word_t d,
                     input logic [2:0] k, input sdc_word_t e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    q.push_back({k, e});
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) hang("pready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input sdc_addr_t a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d}, 3'b100, '0);
  endtask

  task automatic rd(input sdc_addr_t a, input logic [15:0] e);
    apb(1'b0, a, '0, 3'b110, {16'h0, e});
  endtask

  // Each finished transfer retires the oldest expectation.
  always @(negedge pclk) begin
    logic [34:0] e;
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      if (e[34]) cmp({31'h0, pslverr}, {31'h0, e[32]}, "pslverr");
      if (e[33]) cmp(prdata, e[31:0], "prdata");
    end
  end

  // Strobes and cycles from one interrupt pulse to the next.
  task automatic gap(output int s, output int c);
    bit seen;
    seen = 1'b0;
    s = 0;
    c = 0;
    for (int n = 0; n < 20000; n++) begin
      @(negedge pclk);
      if (seen) c++;
      if (seen && mod_strobe === 1'b1) s++;
      if (seen && irq_event === 1'b1) return;
      if (irq_event === 1'b1) seen = 1'b1;
    end
    hang("interrupt");
  endtask

  task automatic cnt(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin
      @(negedge pclk);
      if (irq_event === 1'b1) k++;
    end
  endtask

  // Disabling first restarts filter, counters and ready flag.
  task automatic conv(input logic [2:0] osr, input logic [2:0] dv,
                      input logic [15:0] c2);
    wr(c1a, 16'h0000);
    // The oscillator stand-in is scaled in time; divider codes 0 and 1
    // stand for a converter clock inside its legal band.
    wr(c3a, {dv, osr, 2'b01, 8'h00});
    wr(c2a, c2);
    wr(c1a, 16'h8000);
  endtask

  initial begin
    int s, c, k;
    logic [15:0] v;
    logic [10:0] o;
    logic [10:0] p;
    void'($urandom(52159));
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    cmp({analog_en, analog_rst, chopping_sel_en, irq_event}, 0,
        "reset");
    @(posedge pclk);
    presetn <= 1'b1;
    rd(c1a, 16'h0000);
    rd(c2a, 16'h0000);
    rd(c3a, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom()) & 16'hf7ff;
      idle_mode <= 1'($urandom());
      wr(c1a, 16'h0000);
      wr(c3a, v);
      rd(c3a, v & `SDC_CON3_MASK);
      cmp(channel_sel, v[2:0], "channel");
      wr(c2a, v);
      rd(c2a, v & `SDC_CON2_MASK);
      cmp(chopping_sel_en, v[15:14] == 2'b11, "chopping_sel");
      wr(c1a, v);
      rd(c1a, v & `SDC_CON1_MASK);
      o = {v[15] & ~v[12] & ~(v[13] & idle_mode), v[12], v[10:6], v[4],
           v[2:0]};
      p = {analog_en, analog_rst, gain_sel, dither_sel, offset_meas,
           neg_ref, pos_ref, amp_bw};
      cmp(p[10:9], o[10:9], "run");
      cmp(p[8:4], o[8:4], "gain");
      cmp(p[3:2], o[3:2], "offs");
      cmp(p[1:0], o[1:0], "ref");
    end
    wr(c1a, 16'h0000);
    apb(1'b1, 12'h014, 32'h0000ffff, 3'b101, '0);
    apb(1'b0, 12'h014, '0, 3'b111, '0);
    apb(1'b1, rha, 32'h0000ffff, 3'b000, '0);
    rd(rha, 16'h0000);
    for (int j = 4; j <= 6; j++) begin
      conv(3'(j), 3'h0, 16'hf100);
      gap(s, c);
      cmp(s, 32'h400 >> j, "ratio");
      cmp(c, 4 * s, "rate");
    end
    conv(3'h6, 3'h1, 16'hf100);
    gap(s, c);
    cmp(c, 128, "divided rate");
    // The primary oscillator stand-in ticks every eighth cycle.
    wr(c1a, 16'h0000);
    wr(c3a, 16'h1a00);
    wr(c1a, 16'h8000);
    gap(s, c);
    cmp(c, 128, "primary clock");
    conv(3'h6, 3'h0, 16'he100);
    gap(s, c);
    cmp(s, 80, "fifth");
    rd(rha, 16'h4000);
    rd(rla, 16'h0000);
    conv(3'h6, 3'h0, 16'hf200);
    gap(s, c);
    rd(rha, 16'h0000);
    conv(3'h6, 3'h0, 16'hc100);
    cnt(800, k);
    cmp(k, 1, "rise events");
    conv(3'h6, 3'h0, 16'hd100);
    cnt(800, k);
    cmp(k, 0, "fall quiet");
    ones <= 11'h000;
    cnt(800, k);
    cmp(k >= 1 && k <= 2, 1, "fall events");
    conv(3'h6, 3'h0, 16'hf000);
    repeat (3) gap(s, c);
    rd(c2a, 16'hf001);
    rd(rha, 16'hc000);
    ones <= 11'h010;
    repeat (2) gap(s, c);
    rd(rha, 16'hc000);
    wr(c2a, 16'hf000);
    gap(s, c);
    rd(rha, 16'h4000);
    rd(c2a, 16'hf001);
    wr(c1a, 16'h9000);
    rd(c2a, 16'hf000);
    rd(rha, 16'h0000);
    cnt(400, k);
    cmp(k, 0, "held in reset");
    idle_mode <= 1'b1;
    wr(c1a, 16'ha000);
    cnt(400, k);
    cmp(k, 0, "idle stop");
    idle_mode <= 1'b0;
    cnt(400, k);
    cmp(k >= 1, 1, "idle resume");
    // The enable drops just after a pulse, so the frozen pulse is low.
    gap(s, c);
    @(posedge pclk);
    ce <= 1'b0;
    cnt(400, k);
    cmp(k, 0, "frozen");
    @(posedge pclk);
    ce <= 1'b1;
    gap(s, c);
    cmp(s, 16, "after freeze");
    // A long pattern keeps low bits alive, so rounding becomes visible.
    per <= 11'h400;
    ones <= 11'h204;
    for (int r = 0; r < 4; r++) begin
      conv(3'h0, 3'h0, 16'hf100 | 16'(r << 3));
      gap(s, c);
      rd(rha, r == 3 ? 16'h0100 : 16'h0080);
    end
    close_out();
  end
endmodule // sdc_top_tb
`default_nettype wire
